// *** verilog/rss_top.sv ***
// reset strap sampler: captures memory-line straps after reset
// assumes strap lines settle while reset_n is low; they are async pins
`timescale 1ns/1ns
module rss_top
    import rss_pkg::*;
#(
    parameter int LINES = RSS_LINES
)(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // strap pins
    input  wire logic [LINES-1:0] strap_memory_lines,
    // register port
    input  wire logic [7:0]       addr,
    input  wire logic [7:0]       wr_data,
    input  wire logic             wr_strobe,
    input  wire logic             rd_strobe,
    output logic      [7:0]       rd_data,
    // configuration outputs
    output logic                  isa_low_mem_write_strobe_sel,
    output logic                  pci_clock_output_div3,
    output logic      [2:0]       host_synth_code,
    output logic                  double_speed_core
);
    import rss_pkg::*;

    // ====================
    // helpers
    // one byte of the held image, as a bank register shows it
    function automatic logic [7:0] rss_strap_byte(
        input logic [LINES-1:0] held,
        input int               lsb
    );
        rss_strap_byte = held[lsb +: 8];
    endfunction : rss_strap_byte

    // ====================
    // pin synchronisers; straps are board levels, not timed to clk
    logic [LINES-1:0] sync_a;
    logic [LINES-1:0] sync_b;
    logic [LINES-1:0] next_sync_a;
    logic [LINES-1:0] next_sync_b;

    always_comb begin
        next_sync_a = strap_memory_lines;
        next_sync_b = sync_a;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // ====================
    // capture sequencing: let both sync stages fill, then latch once
    rss_state_e state;
    rss_state_e next_state;
    logic [1:0] wait_cnt;
    logic [1:0] next_wait_cnt;
    logic       capture;

    always_comb begin
        next_state    = state;
        next_wait_cnt = wait_cnt;
        capture       = 1'b0;
        case (state)
            RSS_ST_RESET: begin
                next_state    = RSS_ST_SYNC;
                next_wait_cnt = 2'h0;
            end
            RSS_ST_SYNC: begin
                if (wait_cnt == RSS_SYNC_CYCLES) begin
                    capture    = 1'b1;
                    next_state = RSS_ST_HELD;
                end else begin
                    next_wait_cnt = wait_cnt + 2'h1;
                end
            end
            RSS_ST_HELD: begin
                // only a new reset leaves this state
                next_state = RSS_ST_HELD;
            end
            default: begin
                next_state = RSS_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state    <= RSS_ST_RESET;
            wait_cnt <= 2'h0;
        end else begin
            state    <= next_state;
            wait_cnt <= next_wait_cnt;
        end
    end

    // ====================
    // held strap image; later line activity is ignored
    logic [LINES-1:0] straps;
    logic [LINES-1:0] next_straps;

    always_comb begin
        next_straps = straps;
        if (capture) begin
            next_straps = sync_b;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            straps <= '0;
        end else begin
            straps <= next_straps;
        end
    end

    // ====================
    // writable bit of the pci register; storage only, drives nothing
    logic pci_wr_bit;
    logic next_pci_wr_bit;
    logic pci_wr_hit;

    always_comb begin
        pci_wr_hit      = wr_strobe && (addr == RSS_ADDR_PCICLK);
        next_pci_wr_bit = pci_wr_bit;
        if (capture) begin
            // capture wins; a write on that edge is lost
            next_pci_wr_bit = sync_b[RSS_PCICLK_LSB + RSS_PCICLK_WR_BIT];
        end else if (pci_wr_hit) begin
            next_pci_wr_bit = wr_data[RSS_PCICLK_WR_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pci_wr_bit <= 1'b0;
        end else begin
            pci_wr_bit <= next_pci_wr_bit;
        end
    end

    // ====================
    // register views; speed and type bits pass straight through
    rss_regs_if regs ();
    assign regs.bank01 = rss_strap_byte(straps, RSS_BANK01_LSB);
    assign regs.bank23 = rss_strap_byte(straps, RSS_BANK23_LSB);
    assign regs.pciclk = {2'h0, straps[RSS_PCICLK_HI_LINE], pci_wr_bit,
                          straps[RSS_PCICLK_LSB +: RSS_PCICLK_BITS-1]};
    assign regs.hclk   = {2'h0, straps[RSS_HCLK_LSB +: RSS_HCLK_BITS]};

    rss_reg_port u_port (
        .clk       (clk),
        .reset_n   (reset_n),
        .addr      (addr),
        .rd_strobe (rd_strobe),
        .rd_data   (rd_data),
        .regs      (regs)
    );

    // ====================
    // configuration from held straps; reserved lines are the board's concern
    assign isa_low_mem_write_strobe_sel = straps[RSS_SHARED_PIN_BIT];
    assign pci_clock_output_div3        = straps[RSS_PCI_DIV_BIT];
    assign host_synth_code              = straps[RSS_SYNTH_LSB +: 3];
    assign double_speed_core            = straps[RSS_CORE_MULT_BIT];
endmodule : rss_top

// *** include/rss_pkg.sv ***
// package of constants for the reset strap sampler
// assumes a 10 MHz core clock and an 8-bit register port
package rss_pkg;
    // ====================
    // register offsets
    localparam logic [7:0] RSS_ADDR_BANK01 = 8'h4A;
    localparam logic [7:0] RSS_ADDR_BANK23 = 8'h4B;
    localparam logic [7:0] RSS_ADDR_PCICLK = 8'h4C;
    localparam logic [7:0] RSS_ADDR_HCLK   = 8'h5F;
    // ====================
    // strap line count and field positions
    localparam int RSS_LINES          = 44;
    localparam int RSS_BANK01_LSB     = 0;
    localparam int RSS_BANK23_LSB     = 8;
    localparam int RSS_PCICLK_LSB     = 16;
    localparam int RSS_PCICLK_BITS    = 5;
    localparam int RSS_PCICLK_HI_LINE = 23;
    localparam int RSS_HCLK_LSB       = 21;
    localparam int RSS_HCLK_BITS      = 6;
    localparam int RSS_SHARED_PIN_BIT = 0;
    localparam int RSS_PCI_DIV_BIT    = 17;
    localparam int RSS_SYNTH_LSB      = 24;
    localparam int RSS_CORE_MULT_BIT  = 40;
    localparam int RSS_PCICLK_WR_BIT  = 4;
    localparam logic [7:0] RSS_RD_ZERO = 8'h00;
    // ====================
    // capture sequencing
    typedef enum logic [2:0] {
        RSS_ST_RESET = 3'h1,
        RSS_ST_SYNC  = 3'h2,
        RSS_ST_HELD  = 3'h4
    } rss_state_e;
    localparam logic [1:0] RSS_SYNC_CYCLES = 2'h2;
endpackage : rss_pkg

// *** include/rss_regs_if.sv ***
// register view bundle between capture logic and register port
// assumes both ends share clk
`timescale 1ns/1ns
interface rss_regs_if;
    logic [7:0] bank01;
    logic [7:0] bank23;
    logic [7:0] pciclk;
    logic [7:0] hclk;
    modport source (output bank01, bank23, pciclk, hclk);
    modport sink   (input  bank01, bank23, pciclk, hclk);
endinterface : rss_regs_if

// *** verilog/rss_reg_port.sv ***
// register read port for the strap registers
// assumes strobes are one cycle and on clk
`timescale 1ns/1ns
module rss_reg_port
    import rss_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // bus
    input  wire logic [7:0] addr,
    input  wire logic       rd_strobe,
    output logic      [7:0] rd_data,
    // register view
    rss_regs_if.sink        regs
);
    import rss_pkg::*;
    logic [7:0] next_rd_data;

    // ====================
    // read decode, unmapped reads return zero
    always_comb begin
        next_rd_data = RSS_RD_ZERO;
        if (rd_strobe) begin
            case (addr)
                RSS_ADDR_BANK01: next_rd_data = regs.bank01;
                RSS_ADDR_BANK23: next_rd_data = regs.bank23;
                RSS_ADDR_PCICLK: next_rd_data = regs.pciclk;
                RSS_ADDR_HCLK:   next_rd_data = regs.hclk;
                default:         next_rd_data = RSS_RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= RSS_RD_ZERO;
        end else begin
            rd_data <= next_rd_data;
        end
    end
endmodule : rss_reg_port

// *** verif/rss_board_straps.sv ***
// board strap resistor model on the memory data lines
// assumes the bench picks the user-defined levels
`timescale 1ns/1ns
module rss_board_straps (
    // user-defined levels
    input  wire logic [43:0] user,
    // strap pins
    output logic      [43:0] lines
);
    // ====
    // only mode, speed, type and clock lines follow the user
    localparam logic [43:0] USER_M = 44'h1000702B4B5;
    // upper speed bits and reserved lines pulled up, others pulled down
    localparam logic [43:0] PULL_UP = 44'h4F000FD4948;
    assign lines = (user & USER_M) | PULL_UP;
endmodule : rss_board_straps

// *** verif/rss_top_assertions.sv ***
// checker on the strap sampler ports
// assumes a bind from the bench top, one clock
`timescale 1ns/1ns
module rss_top_assertions
    import rss_pkg::*;
#(parameter int LINES = RSS_LINES)(
    input wire logic             clk,
    input wire logic             reset_n,
    input wire logic [LINES-1:0] strap_memory_lines,
    input wire logic [7:0]       addr,
    input wire logic             rd_strobe,
    input wire logic [7:0]       rd_data,
    input wire logic             isa_low_mem_write_strobe_sel,
    input wire logic             pci_clock_output_div3,
    input wire logic [2:0]       host_synth_code,
    input wire logic             double_speed_core
);
    // ====
    // cycles since release, saturating; snapshot taken on capture edge
    logic [2:0]       cnt;
    logic [LINES-1:0] snap;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) cnt <= 3'h0;
        else if (cnt != 3'h7) cnt <= cnt + 3'h1;
    end
    always_ff @(posedge clk) if (cnt == 3'h3) snap <= strap_memory_lines;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence captured; cnt == 3'h4; endsequence
    sequence rd_at(logic [7:0] a); rd_strobe && addr == a && cnt == 3'h7; endsequence
    isa_sel_a: assert property (captured |-> isa_low_mem_write_strobe_sel == snap[0])
        else $error("shared pin select wrong");
    pci_div_a: assert property (captured |-> pci_clock_output_div3 == snap[17])
        else $error("pci divisor wrong");
    synth_code_a: assert property (captured |-> host_synth_code == snap[26:24])
        else $error("synth code wrong");
    core_mult_a: assert property (captured |-> double_speed_core == snap[40])
        else $error("core multiplier wrong");
    outputs_held_a: assert property (cnt >= 3'h5 |-> $stable({isa_low_mem_write_strobe_sel,
        pci_clock_output_div3, host_synth_code, double_speed_core})) else $error("outputs moved");
    read_bank01_a: assert property (rd_at(RSS_ADDR_BANK01) |=> rd_data == snap[7:0])
        else $error("bank01 read wrong");
    read_bank23_a: assert property (rd_at(RSS_ADDR_BANK23) |=> rd_data == snap[15:8])
        else $error("bank23 read wrong");
    read_hclk_a: assert property (rd_at(RSS_ADDR_HCLK) |=> rd_data == {2'h0, snap[26:21]})
        else $error("pll strap read wrong");
    read_idle_a: assert property (!rd_strobe |=> rd_data == RSS_RD_ZERO)
        else $error("read data not idle");
endmodule : rss_top_assertions

// *** verif/rss_top_tb.sv ***
// self-checking bench for the reset strap sampler
// assumes board model and checker compiled first
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; $display("wrong value at %0t: %h", $time, a); end end
module rss_top_tb;
    import rss_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0, isa_sel, div3, dbl;
    logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data, got;
    logic [43:0] user = 44'h0, s, held;
    logic [2:0] code;
    int bad_count = 0, tests_run = 0;
    rss_board_straps i_rss_board_straps (.user(user), .lines(s));
    rss_top i_rss_top (.clk(clk), .reset_n(reset_n), .strap_memory_lines(s), .addr(addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .isa_low_mem_write_strobe_sel(isa_sel),
        .pci_clock_output_div3(div3), .host_synth_code(code), .double_speed_core(dbl));
    always #50 clk = ~clk;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) begin addr <= a; wr_data <= d; wr_strobe <= 1'b1; end
        @(posedge clk) wr_strobe <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk) begin addr <= a; rd_strobe <= 1'b1; end
        @(posedge clk) rd_strobe <= 1'b0;
        @(posedge clk) got = rd_data;
    endtask : rd
    task automatic boot(input logic [43:0] u);
        reset_n <= 1'b0;
        user <= u;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : boot
    task automatic results;
        $display("compares %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    // ====
    // every synth code, with the other user lines swept too
    initial begin
        for (int i = 0; i < 8; i++) begin
            boot({{17{i[1]}}, 3'(i), {24{i[0]}}});
            `CHK(code, 3'(i))
            `CHK({isa_sel, div3, dbl}, {s[0], s[17], s[40]})
            rd(RSS_ADDR_BANK01);
            `CHK(got, s[7:0])
            rd(RSS_ADDR_BANK23);
            `CHK(got, s[15:8])
            rd(RSS_ADDR_PCICLK);
            `CHK(got, {2'h0, s[23], s[20:16]})
            rd(RSS_ADDR_HCLK);
            `CHK(got, {2'h0, s[26:21]})
            rd(8'h4D);
            `CHK(got, RSS_RD_ZERO)
            $display("boot test %0d done", i);
        end
        // lines move after capture, writes hit read-only bits and the pci writable bit
        held = s;
        user <= 44'h0;
        wr(RSS_ADDR_BANK01, 8'h00);
        wr(RSS_ADDR_PCICLK, 8'h00);
        rd(RSS_ADDR_BANK01);
        `CHK(got, held[7:0])
        rd(RSS_ADDR_PCICLK);
        `CHK(got, {2'h0, held[23], 1'b0, held[19:16]})
        `CHK({code, div3, dbl}, {held[26:24], held[17], held[40]})
        $display("hold test done");
        results;
    end
    initial begin
        #(100 * 3000);
        bad_count++;
        results;
    end
endmodule : rss_top_tb
bind rss_top rss_top_assertions #(.LINES(LINES)) i_rss_top_assertions (.clk(clk), .reset_n(reset_n),
    .strap_memory_lines(strap_memory_lines), .addr(addr), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .isa_low_mem_write_strobe_sel(isa_low_mem_write_strobe_sel), .pci_clock_output_div3(pci_clock_output_div3),
    .host_synth_code(host_synth_code), .double_speed_core(double_speed_core));
